// ---- src/rovp_pkg.sv ----
// package: register map, field positions, reset values and carrier types
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
package rovp_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CMP_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SYSCTL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQEN = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'hC;

    // status_upper_reg fields
    localparam int ST_OP_FLAG = 0;
    localparam int ST_CLAMP_FLAG = 1;
    localparam int ST_OP_ACTIVE = 2;
    localparam int ST_CLAMP_ACTIVE = 3;
    // system_control_low_reg fields
    localparam int SC_AUTO_CLEAR = 0;
    localparam int SC_CONV_SHUTDOWN = 1;
    localparam int SC_CONV_ENABLE = 2;
    localparam int SC_LDO_LSB = 3;
    localparam int LDO_W = 2;
    // irq enable and flag clear fields
    localparam int IE_OP = 0;
    localparam int IE_CLAMP = 1;
    localparam int CL_OP = 0;
    localparam int CL_CLAMP = 1;

    // reset values
    localparam logic RST_AUTO_CLEAR = 1'h0;
    localparam logic RST_CONV_SHUTDOWN = 1'h0;
    localparam logic RST_CONV_ENABLE = 1'h1;
    localparam logic [LDO_W-1:0] RST_LDO_ENABLE = 2'h3;
    localparam logic RST_IRQ_ENABLE = 1'h0;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } rovp_avmm_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
    } rovp_avmm_rsp_t;

    // comparator levels: high while the rectifier output is above the threshold
    typedef struct packed {
        logic opEnAbove;
        logic opDisAbove;
        logic clampEnAbove;
        logic clampDisAbove;
    } rovp_cmp_t;

    // open-drain pin: output level and enable, enable high while driving low
    typedef struct packed {
        logic out;
        logic oe;
    } rovp_od_t;
endpackage

// ---- src/rovp_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous levels
// assumes inputs come from outside the clk domain
`timescale 1ns/100ps
module rovp_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // levels
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } rovp_sync_state_t;

    rovp_sync_state_t st_reg;
    rovp_sync_state_t st_next;

    always_comb begin
        st_next.stage1 = asyncIn;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign syncOut = st_reg.stage2;
endmodule // rovp_sync

// ---- src/rovp_avmm_slave.sv ----
// avalon-mm handshake: one wait cycle, registered read data, completion strobes
// assumes the master holds its request until it sees waitrequest low
`timescale 1ns/100ps
module rovp_avmm_slave (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bus
    input wire rovp_pkg::rovp_avmm_req_t req,
    output rovp_pkg::rovp_avmm_rsp_t rsp,
    // register file side
    input wire logic [rovp_pkg::DATA_W-1:0] readValue,
    output logic wrDone,
    output logic rdDone
);
    typedef struct packed {
        logic ack;
        logic [rovp_pkg::DATA_W-1:0] rdData;
    } rovp_slave_state_t;

    rovp_slave_state_t st_reg;
    rovp_slave_state_t st_next;

    always_comb begin
        st_next.ack = (req.read | req.write) & ~st_reg.ack;
        st_next.rdData = st_reg.rdData;
        if (req.read & ~st_reg.ack) begin
            st_next.rdData = readValue;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // completion edge is the one where waitrequest is low
    assign rsp.waitrequest = (req.read | req.write) & ~st_reg.ack;
    assign rsp.readdata = st_reg.rdData;
    assign wrDone = req.write & st_reg.ack;
    assign rdDone = req.read & st_reg.ack;
endmodule // rovp_avmm_slave

// ---- src/rovp_protect.sv ----
// top: over-power and clamp protection, sticky flags, open-drain interrupt
// assumes comparator levels are asynchronous; pins are resolved outside
`timescale 1ns/100ps

module rovp_protect (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // threshold comparators
    input wire rovp_pkg::rovp_cmp_t cmpIn,
    // register bus
    input wire rovp_pkg::rovp_avmm_req_t avmmReq,
    output rovp_pkg::rovp_avmm_rsp_t avmmRsp,
    // open-drain pins
    output rovp_pkg::rovp_od_t tunePinA,
    output rovp_pkg::rovp_od_t tunePinB,
    output rovp_pkg::rovp_od_t antennaInputA,
    output rovp_pkg::rovp_od_t antennaInputB,
    output rovp_pkg::rovp_od_t irqPin,
    // converter and regulator enables
    output logic converterEnable,
    output logic [rovp_pkg::LDO_W-1:0] ldoEnable
);
    typedef struct packed {
        logic opActive;
        logic clampActive;
        logic opFlag;
        logic clampFlag;
        logic autoClear;
        logic convShutdown;
        logic convEnable;
        logic [rovp_pkg::LDO_W-1:0] ldoEn;
        logic opIe;
        logic clampIe;
        logic irqActive;
    } rovp_state_t;

    rovp_state_t st_reg;
    rovp_state_t st_next;
    rovp_pkg::rovp_cmp_t cmpSync;
    logic [rovp_pkg::DATA_W-1:0] readValue;
    logic wrDone;
    logic rdDone;
    logic [7:0] wrByte;
    logic wrLane0;
    logic opClear;
    logic clampClear;
    logic opSet;
    logic clampSetEvt;

    rovp_sync #(
        .W(rovp_pkg::CMP_W)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .asyncIn(cmpIn),
        .syncOut(cmpSync)
    );

    rovp_avmm_slave u_slave (
        .clk(clk),
        .srst(srst),
        .req(avmmReq),
        .rsp(avmmRsp),
        .readValue(readValue),
        .wrDone(wrDone),
        .rdDone(rdDone)
    );

    function automatic logic hitReg(input logic [rovp_pkg::ADDR_W-1:0] addr,
                                    input logic [rovp_pkg::ADDR_W-1:0] ofs);
        hitReg = (addr == ofs);
    endfunction

    // register read mux, unmapped and clear register read zero
    always_comb begin
        readValue = '0;
        if (hitReg(avmmReq.address, rovp_pkg::OFS_STATUS)) begin
            readValue[rovp_pkg::ST_OP_FLAG] = st_reg.opFlag;
            readValue[rovp_pkg::ST_CLAMP_FLAG] = st_reg.clampFlag;
            readValue[rovp_pkg::ST_OP_ACTIVE] = st_reg.opActive;
            readValue[rovp_pkg::ST_CLAMP_ACTIVE] = st_reg.clampActive;
        end else if (hitReg(avmmReq.address, rovp_pkg::OFS_SYSCTL)) begin
            readValue[rovp_pkg::SC_AUTO_CLEAR] = st_reg.autoClear;
            readValue[rovp_pkg::SC_CONV_SHUTDOWN] = st_reg.convShutdown;
            readValue[rovp_pkg::SC_CONV_ENABLE] = st_reg.convEnable;
            readValue[rovp_pkg::SC_LDO_LSB +: rovp_pkg::LDO_W] = st_reg.ldoEn;
        end else if (hitReg(avmmReq.address, rovp_pkg::OFS_IRQEN)) begin
            readValue[rovp_pkg::IE_OP] = st_reg.opIe;
            readValue[rovp_pkg::IE_CLAMP] = st_reg.clampIe;
        end
    end

    assign wrByte = avmmReq.writedata[7:0];
    assign wrLane0 = wrDone & avmmReq.byteenable[0];

    always_comb begin
        st_next = st_reg;
        st_next.opActive = cmpSync.opEnAbove | (st_reg.opActive & cmpSync.opDisAbove);
        st_next.clampActive = cmpSync.clampEnAbove
            | (st_reg.clampActive & cmpSync.clampDisAbove);
        // set only on a fresh entry into over-power
        opSet = st_next.opActive & ~st_reg.opActive;
        opClear = (wrLane0 & hitReg(avmmReq.address, rovp_pkg::OFS_CLEAR)
                   & wrByte[rovp_pkg::CL_OP])
            | (rdDone & hitReg(avmmReq.address, rovp_pkg::OFS_STATUS) & st_reg.autoClear);
        clampClear = (wrLane0 & hitReg(avmmReq.address, rovp_pkg::OFS_CLEAR)
                      & wrByte[rovp_pkg::CL_CLAMP])
            | (rdDone & hitReg(avmmReq.address, rovp_pkg::OFS_STATUS) & st_reg.autoClear);
        // clear blocked while active; set beats clear
        st_next.opFlag = opSet | (st_reg.opFlag & ~(opClear & ~st_next.opActive));
        // clamp flag set on every cycle the enable comparator level is high, then held until cleared
        st_next.clampFlag = cmpSync.clampEnAbove
            | (st_reg.clampFlag & ~(clampClear & ~st_next.clampActive));
        clampSetEvt = st_next.clampFlag & ~st_reg.clampFlag;
        // software register writes
        if (wrLane0 & hitReg(avmmReq.address, rovp_pkg::OFS_SYSCTL)) begin
            st_next.autoClear = wrByte[rovp_pkg::SC_AUTO_CLEAR];
            st_next.convShutdown = wrByte[rovp_pkg::SC_CONV_SHUTDOWN];
            st_next.convEnable = wrByte[rovp_pkg::SC_CONV_ENABLE];
            st_next.ldoEn = wrByte[rovp_pkg::SC_LDO_LSB +: rovp_pkg::LDO_W];
        end
        if (wrLane0 & hitReg(avmmReq.address, rovp_pkg::OFS_IRQEN)) begin
            st_next.opIe = wrByte[rovp_pkg::IE_OP];
            st_next.clampIe = wrByte[rovp_pkg::IE_CLAMP];
        end
        // converter shutdown on a new clamp flag, only with shutdown select and clamp irq enable both set
        if (clampSetEvt & st_reg.convShutdown & st_reg.clampIe) begin
            st_next.convEnable = 1'h0;
        end
        st_next.irqActive = (st_next.opFlag & st_next.opIe)
            | (st_next.clampFlag & st_next.clampIe);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.autoClear <= rovp_pkg::RST_AUTO_CLEAR;
            st_reg.convShutdown <= rovp_pkg::RST_CONV_SHUTDOWN;
            st_reg.convEnable <= rovp_pkg::RST_CONV_ENABLE;
            st_reg.ldoEn <= rovp_pkg::RST_LDO_ENABLE;
            st_reg.opIe <= rovp_pkg::RST_IRQ_ENABLE;
            st_reg.clampIe <= rovp_pkg::RST_IRQ_ENABLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // tune pins pull low while over-power is active
    assign tunePinA = '{out: 1'b0, oe: st_reg.opActive};
    assign tunePinB = '{out: 1'b0, oe: st_reg.opActive};
    // antenna inputs shorted while clamp is active
    assign antennaInputA = '{out: 1'b0, oe: st_reg.clampActive};
    assign antennaInputB = '{out: 1'b0, oe: st_reg.clampActive};
    // interrupt released once no enabled flag remains
    assign irqPin = '{out: 1'b0, oe: st_reg.irqActive};
    assign converterEnable = st_reg.convEnable;
    assign ldoEnable = st_reg.ldoEn;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    tunePins_on_a: assert property (cmpSync.opEnAbove |=> tunePinA.oe && tunePinB.oe)
        else $error("tune pins not pulled on over-power");
    opFlag_set_a: assert property ($rose(st_reg.opActive) |-> st_reg.opFlag)
        else $error("over-power flag not set on entry");
    tunePins_release_a: assert property (
        st_reg.opActive && !cmpSync.opDisAbove && !cmpSync.opEnAbove |=> !tunePinA.oe)
        else $error("tune pins held below disable threshold");
    irq_op_a: assert property (st_reg.opFlag && st_reg.opIe |-> irqPin.oe)
        else $error("interrupt not driven for over-power");
    opClr_write_a: assert property (
        wrLane0 && hitReg(avmmReq.address, rovp_pkg::OFS_CLEAR) && wrByte[rovp_pkg::CL_OP]
        && !cmpSync.opEnAbove && !cmpSync.opDisAbove |=> !st_reg.opFlag)
        else $error("over-power flag not cleared by write");
    opFlag_rearm_a: assert property ($rose(st_reg.opFlag) |-> $rose(st_reg.opActive))
        else $error("over-power flag set without fresh entry");
    clamp_short_a: assert property (
        cmpSync.clampEnAbove |=> antennaInputA.oe && antennaInputB.oe)
        else $error("antenna inputs not shorted");
    clampFlag_set_a: assert property (cmpSync.clampEnAbove |=> st_reg.clampFlag)
        else $error("clamp flag not set");
    conv_keep_a: assert property (
        $rose(st_reg.clampFlag) && !$past(st_reg.convShutdown) && $past(st_reg.convEnable)
        && !$past(wrDone) |-> st_reg.convEnable)
        else $error("converter disabled without shutdown select");
    conv_off_a: assert property (
        $rose(st_reg.clampFlag) && $past(st_reg.convShutdown) && $past(st_reg.clampIe)
        |-> !st_reg.convEnable)
        else $error("converter not disabled on clamp");
    ldo_keep_a: assert property (
        $rose(st_reg.clampFlag) && !$past(wrDone) |-> $stable(ldoEnable))
        else $error("regulator enables changed by clamp");

    ldo_write_only_a: assert property (
        !$past(srst) && !$past(wrDone) |-> $stable(ldoEnable))
        else $error("regulator enables changed without a write");
    op_always_on_a: assert property (cmpSync.opEnAbove |=> st_reg.opActive)
        else $error("over-power detection not active");
    clamp_always_on_a: assert property (cmpSync.clampEnAbove |=> st_reg.clampActive)
        else $error("clamp detection not active");
    tunePins_hold_a: assert property (
        st_reg.opActive && cmpSync.opDisAbove |=> tunePinA.oe && tunePinB.oe)
        else $error("tune pins released above disable threshold");
    opClr_read_a: assert property (
        rdDone && hitReg(avmmReq.address, rovp_pkg::OFS_STATUS) && st_reg.autoClear
        && !cmpSync.opEnAbove && !cmpSync.opDisAbove |=> !st_reg.opFlag)
        else $error("over-power flag not cleared by status read");
    opFlag_hold_a: assert property (
        st_reg.opFlag && st_reg.opActive && cmpSync.opDisAbove |=> st_reg.opFlag)
        else $error("over-power flag cleared while still active");
    irq_release_a: assert property (
        !st_reg.opFlag && !st_reg.clampFlag |-> !irqPin.oe)
        else $error("interrupt driven with no flag set");
    clamp_hold_a: assert property (
        st_reg.clampActive && cmpSync.clampDisAbove
        |=> antennaInputA.oe && antennaInputB.oe)
        else $error("antenna shorts released above disable threshold");
    clamp_release_a: assert property (
        st_reg.clampActive && !cmpSync.clampDisAbove && !cmpSync.clampEnAbove
        |=> !antennaInputA.oe && !antennaInputB.oe)
        else $error("antenna shorts held below disable threshold");
    irq_clamp_a: assert property (st_reg.clampFlag && st_reg.clampIe |-> irqPin.oe)
        else $error("interrupt not driven for clamp");
    clampClr_write_a: assert property (
        wrLane0 && hitReg(avmmReq.address, rovp_pkg::OFS_CLEAR)
        && wrByte[rovp_pkg::CL_CLAMP]
        && !cmpSync.clampEnAbove && !cmpSync.clampDisAbove |=> !st_reg.clampFlag)
        else $error("clamp flag not cleared by write");
    clampClr_read_a: assert property (
        rdDone && hitReg(avmmReq.address, rovp_pkg::OFS_STATUS) && st_reg.autoClear
        && !cmpSync.clampEnAbove && !cmpSync.clampDisAbove |=> !st_reg.clampFlag)
        else $error("clamp flag not cleared by status read");
    conv_reset_a: assert property ($fell(srst) |-> !st_reg.convShutdown)
        else $error("shutdown select not zero after reset");
    conv_stay_off_a: assert property (
        !st_reg.convEnable && !wrDone |=> !st_reg.convEnable)
        else $error("converter enabled without a write");
    irq_or_a: assert property (
        irqPin.oe |-> (st_reg.opFlag && st_reg.opIe) || (st_reg.clampFlag && st_reg.clampIe))
        else $error("interrupt driven without an enabled flag");
    opSet_wins_a: assert property (opSet && opClear |=> st_reg.opFlag)
        else $error("over-power clear beat a set");
    clampSet_wins_a: assert property (
        cmpSync.clampEnAbove && clampClear |=> st_reg.clampFlag)
        else $error("clamp clear beat a set");
endmodule // rovp_protect

// ---- verif/rovp_host_model.sv ----
// host side of the interrupt line: pull-up resistor and the resolved level
// assumes the device drives the line low only while irqPin.oe is high
`timescale 1ns/100ps
module rovp_host_model (
    // open-drain interrupt from the device
    input wire rovp_pkg::rovp_od_t irqPin,
    // level the host sees
    output logic irqLine
);
    assign irqLine = irqPin.oe ? irqPin.out : 1'b1;
endmodule // rovp_host_model

// ---- verif/rovp_protect_bench.sv ----
// bench: drives comparators and the avalon-mm bus, checks pins and registers
// assumes one clock domain; comparator levels settle in state within a few edges
`timescale 1ns/100ps
module rovp_protect_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    rovp_pkg::rovp_cmp_t cmpIn = '0;
    rovp_pkg::rovp_avmm_req_t req = '0;
    rovp_pkg::rovp_avmm_rsp_t rsp;
    rovp_pkg::rovp_od_t tA, tB, aA, aB, irq;
    logic convEn, irqLine, opA, clA;
    logic [1:0] ldo;
    logic [31:0] r;
    int errors = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    rovp_protect u_rovp_protect (.clk(clk), .srst(srst), .cmpIn(cmpIn), .avmmReq(req),
        .avmmRsp(rsp), .tunePinA(tA), .tunePinB(tB), .antennaInputA(aA),
        .antennaInputB(aB), .irqPin(irq), .converterEnable(convEn), .ldoEnable(ldo));
    rovp_host_model u_rovp_host_model (.irqPin(irq), .irqLine(irqLine));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.byteenable <= 4'hF;
        req.writedata <= d;
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic cmp(input logic [3:0] v);
        @(posedge clk);
        cmpIn <= v;
        repeat (5) @(posedge clk);
    endtask

    // pin pull-downs as {tuneA, tuneB, antA, antB}
    task automatic pins(input logic [3:0] exp);
        chk({28'h0, tA.oe, tB.oe, aA.oe, aB.oe}, {28'h0, exp});
        // open-drain outputs only ever pull low
        chk({27'h0, tA.out, tB.out, aA.out, aB.out, irq.out}, 32'h0);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(14));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd(rovp_pkg::OFS_SYSCTL, 32'h1C);
        rd(rovp_pkg::OFS_IRQEN, 32'h0);
        rd(rovp_pkg::OFS_CLEAR, 32'h0);
        rd(4'h2, 32'h0);
        wr(rovp_pkg::OFS_IRQEN, 32'h1);
        cmp(4'hC);
        pins(4'hC);
        chk(irqLine, 1'b0);
        rd(rovp_pkg::OFS_STATUS, 32'h5);
        cmp(4'h4);
        pins(4'hC);
        cmp(4'h0);
        pins(4'h0);
        chk(irqLine, 1'b0);
        wr(rovp_pkg::OFS_CLEAR, 32'h1);
        rd(rovp_pkg::OFS_STATUS, 32'h0);
        cmp(4'h0);
        chk(irqLine, 1'b1);
        cmp(4'hC);
        rd(rovp_pkg::OFS_STATUS, 32'h5);
        wr(rovp_pkg::OFS_SYSCTL, 32'h1D);
        cmp(4'h0);
        rd(rovp_pkg::OFS_STATUS, 32'h1);
        rd(rovp_pkg::OFS_STATUS, 32'h0);
        wr(rovp_pkg::OFS_SYSCTL, 32'h1E);
        wr(rovp_pkg::OFS_IRQEN, 32'h2);
        cmp(4'h3);
        pins(4'h3);
        chk(convEn, 1'b0);
        chk(ldo, 2'h3);
        rd(rovp_pkg::OFS_STATUS, 32'hA);
        cmp(4'h1);
        pins(4'h3);
        cmp(4'h0);
        pins(4'h0);
        chk(irqLine, 1'b0);
        wr(rovp_pkg::OFS_CLEAR, 32'h2);
        rd(rovp_pkg::OFS_STATUS, 32'h0);
        wr(rovp_pkg::OFS_SYSCTL, 32'h1E);
        rd(rovp_pkg::OFS_SYSCTL, 32'h1E);
        chk(convEn, 1'b1);
        wr(rovp_pkg::OFS_SYSCTL, 32'h1D);
        cmp(4'h3);
        chk(convEn, 1'b1);
        cmp(4'h0);
        rd(rovp_pkg::OFS_STATUS, 32'h2);
        rd(rovp_pkg::OFS_STATUS, 32'h0);
        wr(rovp_pkg::OFS_SYSCTL, 32'h1C);
        wr(rovp_pkg::OFS_IRQEN, 32'h3);
        cmp(4'hF);
        rd(rovp_pkg::OFS_STATUS, 32'hF);
        cmp(4'h0);
        wr(rovp_pkg::OFS_IRQEN, 32'h0);
        cmp(4'h0);
        chk(irqLine, 1'b1);
        wr(rovp_pkg::OFS_IRQEN, 32'h3);
        wr(rovp_pkg::OFS_CLEAR, 32'h1);
        cmp(4'h0);
        chk(irqLine, 1'b0);
        wr(rovp_pkg::OFS_CLEAR, 32'h2);
        cmp(4'h0);
        chk(irqLine, 1'b1);
        // reset in mid-run restores control defaults
        wr(rovp_pkg::OFS_SYSCTL, 32'h3);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(rovp_pkg::OFS_SYSCTL, 32'h1C);
        chk(convEn, 1'b1);
        // random levels, each enable comparator implies its disable comparator
        opA = 1'b0;
        clA = 1'b0;
        repeat (40) begin
            r = $urandom;
            cmp({r[0], r[0] | r[1], r[2], r[2] | r[3]});
            opA = cmpIn.opEnAbove | (opA & cmpIn.opDisAbove);
            clA = cmpIn.clampEnAbove | (clA & cmpIn.clampDisAbove);
            pins({opA, opA, clA, clA});
        end
        wrap_up();
    end
endmodule // rovp_protect_bench
